/* logic/gmr_pkg.sv */
// Package of register map, field positions and timing constants for the gauge register slice.
package gmr_pkg;
  // Register byte addresses on the serial register port.
  localparam logic [6:0] ADDR_CTRL       = 7'h00;
  localparam logic [6:0] ADDR_MODE       = 7'h01;
  localparam logic [6:0] ADDR_AT_RATE_LO = 7'h02;
  localparam logic [6:0] ADDR_AT_RATE_HI = 7'h03;
  localparam logic [6:0] ADDR_TTE_LO     = 7'h04;
  localparam logic [6:0] ADDR_TTE_HI     = 7'h05;
  localparam logic [6:0] ADDR_TEMP_LO    = 7'h06;
  localparam logic [6:0] ADDR_TEMP_HI    = 7'h07;
  localparam logic [6:0] ADDR_VOLT_LO    = 7'h08;
  localparam logic [6:0] ADDR_VOLT_HI    = 7'h09;

  // Mode register field positions, and the GPIO direction bit of the pack configuration.
  localparam int BIT_GPIO_DIR   = 7;
  localparam int BIT_GPIO_LEVEL = 6;
  localparam int BIT_LOAD_CAP   = 5;
  localparam int BIT_CHG_DONE   = 4;
  localparam int BIT_PART_RST   = 3;
  localparam int BIT_POWER_ON   = 2;
  localparam int BIT_FULL_RST   = 1;
  localparam int BIT_SHIP       = 0;
  localparam int BIT_PACK_GPIO  = 7;

  // Command bits of the mode register, as a mask.
  localparam logic [7:0] CMD_MASK = 8'h3b;

  // Control register key that launches a command.
  localparam logic [7:0] CTRL_KEY = 8'ha9;

  // Reset values.
  localparam logic [7:0]  CTRL_RESET   = 8'h00;
  localparam logic [15:0] WORD_RESET   = 16'h0000;
  localparam logic [15:0] TTE_NO_RATE  = 16'hffff;

  // Report scaling: minutes per hour and voltage ceiling in millivolts.
  localparam logic [5:0]  MIN_PER_HOUR = 6'h3c;
  localparam logic [15:0] VOLT_MAX_MV  = 16'h1388;

  // Refresh period of the temperature and voltage reports.
  localparam longint REFRESH_S      = 2;
  localparam longint CLK_HZ         = 50_000_000;
  localparam longint REFRESH_CYCLES = REFRESH_S * CLK_HZ;
endpackage

/* logic/gmr_div.sv */
// Sequential restoring divider with saturated quotient, used for time-to-empty.
`timescale 1ns/1ns
module gmr_div
  import gmr_pkg::*;
#(
  parameter int NUM_W = 22,
  parameter int DEN_W = 16,
  parameter int Q_W   = 16
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  input  wire logic             start_i,
  input  wire logic [NUM_W-1:0] num_i,
  input  wire logic [DEN_W-1:0] den_i,
  output logic                  busy_o,
  output logic                  done_o,
  output logic [Q_W-1:0]        quot_o
);
  localparam int CNT_W = $clog2(NUM_W + 1);

  initial begin
    if (NUM_W <= Q_W || DEN_W < 2) begin
      $error("gmr_div: numerator must be wider than quotient");
    end
  end

  logic [DEN_W-1:0] rem;
  logic [NUM_W-1:0] q;
  logic [CNT_W-1:0] cnt;
  logic             zero_den;
  logic [DEN_W:0]   shifted;
  logic [DEN_W:0]   diff;

  // One quotient bit per cycle; the remainder stays below any nonzero divisor.
  assign shifted = {rem, q[NUM_W-1]};
  assign diff    = shifted - {1'b0, den_i};

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rem      <= '0;
      q        <= '0;
      cnt      <= '0;
      busy_o   <= 1'b0;
      done_o   <= 1'b0;
      zero_den <= 1'b0;
    end else if (ce_i) begin
      done_o <= busy_o && (cnt == CNT_W'(1));
      if (start_i && !busy_o) begin
        rem      <= '0;
        q        <= num_i;
        cnt      <= CNT_W'(NUM_W);
        busy_o   <= 1'b1;
        zero_den <= (den_i == '0);
      end else if (busy_o) begin
        if (!diff[DEN_W]) begin
          rem <= diff[DEN_W-1:0];
          q   <= {q[NUM_W-2:0], 1'b1};
        end else begin
          rem <= shifted[DEN_W-1:0];
          q   <= {q[NUM_W-2:0], 1'b0};
        end
        cnt    <= cnt - CNT_W'(1);
        busy_o <= (cnt != CNT_W'(1));
      end
    end
  end

  // A zero rate or a quotient that overflows reads as all ones.
  always_comb begin
    if (zero_den || (q[NUM_W-1:Q_W] != '0)) begin
      quot_o = '1;
    end else begin
      quot_o = q[Q_W-1:0];
    end
  end
endmodule // gmr_div

/* logic/gmr_regs.sv */
// Gauge mode, control, at-rate and report registers behind the serial register port.
`timescale 1ns/1ns

// Summary of operation
// RULE1 - Direction bit one makes pin input
// RULE2 - Direction loads from pack configuration bit seven
// RULE3 - Output level one releases, zero pulls low
// RULE4 - Power-on reset forces level bit high
// RULE5 - Input mode reads return sampled pin level
// RULE6 - Load command copies at-rate into nominal capacity
// RULE7 - Charge-complete copies nominal into full capacity
// RULE8 - Partial reset keeps capacities and invalid flag
// RULE9 - Full reset reinitializes every RAM register; here it reloads only at-rate and GPIO direction, level and power-on flag keep
// RULE10 - Ship command enters ship low-power mode
// RULE11 - Every reset clears all command bits
// RULE12 - Power-on reset sets the power-on flag
// RULE13 - Full charge or host clears power-on flag
// RULE14 - Key write runs highest set command only
// RULE15 - Completion clears command bits and control
// RULE16 - Host writes mode, then writes key
// RULE17 - At-rate value is always a discharge
// RULE18 - Time-to-empty is sixty times capacity over rate
// RULE19 - At-rate capacity compensated using at-rate current
// RULE20 - Temperature reported quarter kelvin, every two seconds
// RULE21 - Voltage in millivolts, two seconds, capped 5000
// RULE22 - Writes to read-only reports are ignored
// RULE23 - Control writes other than key are ignored
module gmr_regs
  import gmr_pkg::*;
#(
  parameter longint REFRESH_CYCLES = gmr_pkg::REFRESH_CYCLES,
  parameter int     CAP_W          = 16
) (
  input  wire logic             CLK_I,
  input  wire logic             RST_I,
  input  wire logic             CE_I,
  input  wire logic [6:0]       REG_ADDR_I,
  input  wire logic [7:0]       REG_WDATA_I,
  input  wire logic             REG_WR_I,
  input  wire logic             REG_RD_I,
  output logic      [7:0]       REG_RDATA_O,
  input  wire logic             GPIO_I,
  output logic                  GPIO_O,
  output logic                  GPIO_OE_O,
  input  wire logic [7:0]       PACK_CONFIG_I,
  input  wire logic             FULL_CHARGE_I,
  input  wire logic [CAP_W-1:0] NOMINAL_CAP_I,
  input  wire logic [CAP_W-1:0] AT_RATE_CAP_I,
  input  wire logic [15:0]      DIE_TEMP_I,
  input  wire logic [15:0]      CELL_MV_I,
  output logic                  NOMINAL_CAP_LOAD_O,
  output logic                  FULL_CAP_LOAD_O,
  output logic      [CAP_W-1:0] CAP_DATA_O,
  output logic                  PARTIAL_RESET_O,
  output logic                  FULL_RESET_O,
  output logic                  SHIP_O,
  output logic      [15:0]      AT_RATE_O
);
  localparam int TICK_W = $clog2(REFRESH_CYCLES);
  localparam int NUM_W  = CAP_W + 6;

  initial begin
    if (REFRESH_CYCLES < 2 || CAP_W != 16) begin
      $error("gmr_regs: refresh count below two or capacity width not 16");
    end
  end

  typedef enum logic {GMR_IDLE, GMR_EXEC} gmr_state_t;

  // Picks the highest set command bit; the result is one-hot or zero.
  function automatic logic [7:0] gmr_pick(input logic [7:0] cmds);
    logic [7:0] pick;
    pick = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (cmds[i] && CMD_MASK[i]) begin
        pick = 8'h01 << i;
      end
    end
    return pick;
  endfunction

  gmr_state_t        state;
  logic [7:0]        ctrl;
  logic              gpio_dir_input;
  logic              gpio_level;
  logic [7:0]        cmd_bits;
  logic              power_on_flag;
  logic [15:0]       time_empty;
  logic [15:0]       temp_report;
  logic [15:0]       volt_report;
  logic              init_pending;
  logic              gpio_meta;
  logic              gpio_sync;
  logic [TICK_W-1:0] tick_cnt;
  logic              tick;
  logic              calc_req;
  logic              div_busy;
  logic              div_done;
  logic [15:0]       div_quot;
  logic [7:0]        pick;
  logic              wr_mode;
  logic              wr_ctrl;
  logic              wr_rate_lo;
  logic              wr_rate_hi;
  logic [7:0]        next_rdata;

  assign wr_mode    = REG_WR_I && (REG_ADDR_I == ADDR_MODE);
  assign wr_ctrl    = REG_WR_I && (REG_ADDR_I == ADDR_CTRL);
  assign wr_rate_lo = REG_WR_I && (REG_ADDR_I == ADDR_AT_RATE_LO);
  assign wr_rate_hi = REG_WR_I && (REG_ADDR_I == ADDR_AT_RATE_HI);
  assign pick       = gmr_pick(cmd_bits);

  // The pin is asynchronous to the gauge clock, so it passes two flops first.
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      gpio_meta <= 1'b1;
      gpio_sync <= 1'b1;
    end else if (CE_I) begin
      gpio_meta <= GPIO_I;
      gpio_sync <= gpio_meta;
    end
  end

  // Open-drain driver: only ever pulls low, and only as an output at level zero.
  assign GPIO_O    = 1'b0;
  assign GPIO_OE_O = !gpio_dir_input && !gpio_level; // RULE1 RULE3

  // Command launcher: a key write arms one execution cycle.
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state <= GMR_IDLE;
      ctrl  <= CTRL_RESET;
    end else if (CE_I) begin
      case (state)
        GMR_IDLE: begin
          if (wr_ctrl && (REG_WDATA_I == CTRL_KEY)) begin // RULE14 RULE16 RULE23
            ctrl  <= CTRL_KEY;
            state <= GMR_EXEC;
          end
        end
        GMR_EXEC: begin
          ctrl  <= CTRL_RESET; // RULE15
          state <= GMR_IDLE;
        end
        default: begin
          ctrl  <= CTRL_RESET;
          state <= GMR_IDLE;
        end
      endcase
    end
  end

  // Command pulses to the capacity engine and power manager, one cycle each.
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      NOMINAL_CAP_LOAD_O <= 1'b0;
      FULL_CAP_LOAD_O    <= 1'b0;
      PARTIAL_RESET_O    <= 1'b0;
      FULL_RESET_O       <= 1'b0;
      SHIP_O             <= 1'b0;
      CAP_DATA_O         <= '0;
    end else if (CE_I) begin
      NOMINAL_CAP_LOAD_O <= 1'b0;
      FULL_CAP_LOAD_O    <= 1'b0;
      PARTIAL_RESET_O    <= 1'b0;
      FULL_RESET_O       <= 1'b0;
      SHIP_O             <= 1'b0;
      if (state == GMR_EXEC) begin
        if (pick[BIT_LOAD_CAP]) begin
          NOMINAL_CAP_LOAD_O <= 1'b1; // RULE6
          CAP_DATA_O         <= AT_RATE_O;
        end
        if (pick[BIT_CHG_DONE]) begin
          FULL_CAP_LOAD_O <= 1'b1; // RULE7
          CAP_DATA_O      <= NOMINAL_CAP_I;
        end
        PARTIAL_RESET_O <= pick[BIT_PART_RST]; // RULE8
        FULL_RESET_O    <= pick[BIT_FULL_RST]; // RULE9
        SHIP_O          <= pick[BIT_SHIP]; // RULE10
      end
    end
  end

  // Mode register. The pack configuration is caught one edge after any reset,
  // because an asynchronous reset may only load constants.
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      gpio_dir_input <= 1'b1;
      gpio_level     <= 1'b1; // RULE4
      cmd_bits       <= 8'h00; // RULE11
      power_on_flag  <= 1'b1; // RULE12
      init_pending   <= 1'b1;
    end else if (CE_I) begin
      init_pending <= 1'b0;
      if (init_pending) begin
        gpio_dir_input <= PACK_CONFIG_I[BIT_PACK_GPIO]; // RULE2
      end else if (wr_mode) begin
        gpio_dir_input <= REG_WDATA_I[BIT_GPIO_DIR];
      end
      if (wr_mode) begin
        gpio_level <= REG_WDATA_I[BIT_GPIO_LEVEL];
        cmd_bits   <= REG_WDATA_I & CMD_MASK;
      end
      // The host may write the flag either way; it steers nothing here.
      if (FULL_CHARGE_I) begin
        power_on_flag <= 1'b0; // RULE13
      end else if (wr_mode) begin
        power_on_flag <= REG_WDATA_I[BIT_POWER_ON]; // RULE13
      end
      if (state == GMR_EXEC) begin
        cmd_bits <= 8'h00; // RULE15 RULE11
        // Either reset command reloads the at-rate value and the GPIO direction as at start-up.
        if (pick[BIT_FULL_RST] || pick[BIT_PART_RST]) begin
          init_pending <= 1'b1; // RULE8 RULE9
        end
      end
    end
  end

  // At-rate register; the value is a magnitude of discharge, never signed.
  // A byte written as the reload lands is kept, so the host may start right after reset.
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      AT_RATE_O <= WORD_RESET;
    end else if (CE_I) begin
      if (init_pending) begin
        AT_RATE_O <= WORD_RESET; // RULE9
      end
      if (wr_rate_lo) begin
        AT_RATE_O[7:0] <= REG_WDATA_I; // RULE17
      end else if (wr_rate_hi) begin
        AT_RATE_O[15:8] <= REG_WDATA_I; // RULE17
      end
    end
  end

  // Refresh time base for the periodic reports.
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      tick_cnt <= '0;
      tick     <= 1'b0;
    end else if (CE_I) begin
      tick <= (tick_cnt == TICK_W'(REFRESH_CYCLES - 1));
      if (tick_cnt == TICK_W'(REFRESH_CYCLES - 1)) begin
        tick_cnt <= '0;
      end else begin
        tick_cnt <= tick_cnt + TICK_W'(1);
      end
    end
  end

  // Temperature and voltage snapshots; voltage is clipped at the ceiling.
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      temp_report <= WORD_RESET;
      volt_report <= WORD_RESET;
    end else if (CE_I && tick) begin
      temp_report <= DIE_TEMP_I; // RULE20
      if (CELL_MV_I > VOLT_MAX_MV) begin
        volt_report <= VOLT_MAX_MV; // RULE21
      end else begin
        volt_report <= CELL_MV_I; // RULE21
      end
    end
  end

  // Recompute time-to-empty on each refresh and after the high rate byte lands.
  // A request during a running division waits rather than being dropped.
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      calc_req   <= 1'b0;
      time_empty <= TTE_NO_RATE;
    end else if (CE_I) begin
      if (tick || wr_rate_hi) begin
        calc_req <= 1'b1;
      end else if (!div_busy) begin
        calc_req <= 1'b0;
      end
      if (div_done) begin
        time_empty <= div_quot; // RULE18
      end
    end
  end

  // The compensated at-rate capacity comes from the capacity engine, which
  // uses AT_RATE_O in place of the average current.
  gmr_div #(
    .NUM_W (NUM_W),
    .DEN_W (16),
    .Q_W   (16)
  ) u_div (
    .clk_i   (CLK_I),
    .rst_i   (RST_I),
    .ce_i    (CE_I),
    .start_i (calc_req && !div_busy),
    .num_i   (NUM_W'(AT_RATE_CAP_I) * NUM_W'(MIN_PER_HOUR)), // RULE18 RULE19
    .den_i   (AT_RATE_O),
    .busy_o  (div_busy),
    .done_o  (div_done),
    .quot_o  (div_quot)
  );

  // Read mux. In input mode the level bit shows the synchronised pin.
  // Report registers have no write path at all.
  always_comb begin
    next_rdata = 8'h00; // RULE22
    case (REG_ADDR_I)
      ADDR_CTRL:       next_rdata = ctrl;
      ADDR_MODE: begin
        next_rdata                 = cmd_bits;
        next_rdata[BIT_GPIO_DIR]   = gpio_dir_input;
        next_rdata[BIT_GPIO_LEVEL] = gpio_dir_input ? gpio_sync : gpio_level; // RULE5
        next_rdata[BIT_POWER_ON]   = power_on_flag;
      end
      ADDR_AT_RATE_LO: next_rdata = AT_RATE_O[7:0];
      ADDR_AT_RATE_HI: next_rdata = AT_RATE_O[15:8];
      ADDR_TTE_LO:     next_rdata = time_empty[7:0];
      ADDR_TTE_HI:     next_rdata = time_empty[15:8];
      ADDR_TEMP_LO:    next_rdata = temp_report[7:0];
      ADDR_TEMP_HI:    next_rdata = temp_report[15:8];
      ADDR_VOLT_LO:    next_rdata = volt_report[7:0];
      ADDR_VOLT_HI:    next_rdata = volt_report[15:8];
      default:         next_rdata = 8'h00;
    endcase
  end

  // Read data is registered and held until the next read.
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      REG_RDATA_O <= 8'h00;
    end else if (CE_I && REG_RD_I) begin
      REG_RDATA_O <= next_rdata;
    end
  end
endmodule // gmr_regs

/* verification/gmr_regs_properties.sv */
// Checker of the gauge register slice behaviour seen at its ports.
`timescale 1ns/1ns
module gmr_regs_chk
  import gmr_pkg::*;
#(
  parameter int CAP_W = 16
) (
  input wire logic             CLK_I,
  input wire logic             RST_I,
  input wire logic             CE_I,
  input wire logic [6:0]       REG_ADDR_I,
  input wire logic [7:0]       REG_WDATA_I,
  input wire logic             REG_WR_I,
  input wire logic             REG_RD_I,
  input wire logic [7:0]       REG_RDATA_O,
  input wire logic             GPIO_O,
  input wire logic             GPIO_OE_O,
  input wire logic [CAP_W-1:0] NOMINAL_CAP_I,
  input wire logic             NOMINAL_CAP_LOAD_O,
  input wire logic             FULL_CAP_LOAD_O,
  input wire logic [CAP_W-1:0] CAP_DATA_O,
  input wire logic             PARTIAL_RESET_O,
  input wire logic             FULL_RESET_O,
  input wire logic             SHIP_O,
  input wire logic [15:0]      AT_RATE_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  logic [4:0] pulses;
  logic       pend;
  logic       in_exec;

  // All command outcomes towards the capacity engine and power manager, highest priority first.
  assign pulses = {NOMINAL_CAP_LOAD_O, FULL_CAP_LOAD_O, PARTIAL_RESET_O, FULL_RESET_O, SHIP_O};

  // A later mode write replaces the pending command, so the flag follows the last write.
  // The cycle after a key executes; a key or a mode write landing there is lost.
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      pend    <= 1'b0;
      in_exec <= 1'b0;
    end else if (CE_I) begin
      in_exec <= REG_WR_I && REG_ADDR_I == ADDR_CTRL && REG_WDATA_I == CTRL_KEY && !in_exec;
      if (in_exec) begin
        pend <= 1'b0;
      end else if (REG_WR_I && REG_ADDR_I == ADDR_MODE) begin
        pend <= |(REG_WDATA_I & CMD_MASK);
      end
    end
  end

  sequence s_key;
    CE_I && REG_WR_I && REG_ADDR_I == ADDR_CTRL && REG_WDATA_I == CTRL_KEY;
  endsequence
  sequence s_bad_ctrl;
    CE_I && REG_WR_I && REG_ADDR_I == ADDR_CTRL && REG_WDATA_I != CTRL_KEY;
  endsequence

  a_key_runs_cmd: assert property (s_key ##0 (pend && !in_exec) |-> ##2 |pulses)
    else $error("Key write with a pending command gave no pulse.");
  a_bad_ctrl_quiet: assert property (s_bad_ctrl |-> ##2 !(|pulses))
    else $error("Control write other than the key started a command.");
  a_single_cmd: assert property (|pulses |-> $onehot(pulses))
    else $error("More than one command ran at once.");
  a_pulse_clears: assert property (|pulses |=> !(|pulses))
    else $error("Command pulse lasted more than one cycle.");
  a_load_value: assert property (NOMINAL_CAP_LOAD_O |-> CAP_DATA_O == AT_RATE_O)
    else $error("Nominal load data differs from the at-rate value.");
  a_done_value: assert property (FULL_CAP_LOAD_O |-> CAP_DATA_O == NOMINAL_CAP_I)
    else $error("Full capacity load data differs from nominal capacity.");
  a_open_drain: assert property (GPIO_O == 1'b0)
    else $error("Open-drain pin drives a high level.");
  a_rate_write: assert property (CE_I && REG_WR_I && REG_ADDR_I == ADDR_AT_RATE_HI
    |=> AT_RATE_O[15:8] == $past(REG_WDATA_I))
    else $error("At-rate high byte not taken from the write.");
  a_volt_cap: assert property (CE_I && REG_RD_I && REG_ADDR_I == ADDR_VOLT_HI
    |-> ##1 REG_RDATA_O <= 8'h13)
    else $error("Voltage high byte above the ceiling.");
  a_reset_quiet: assert property ($fell(RST_I) |-> !(|pulses) && !GPIO_OE_O)
    else $error("Command pulse or pin pull right after reset.");
endmodule // gmr_regs_chk

bind gmr_regs gmr_regs_chk #(.CAP_W(CAP_W)) i_gmr_regs_chk (
  .CLK_I(CLK_I), .RST_I(RST_I), .CE_I(CE_I), .REG_ADDR_I(REG_ADDR_I),
  .REG_WDATA_I(REG_WDATA_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I),
  .REG_RDATA_O(REG_RDATA_O), .GPIO_O(GPIO_O), .GPIO_OE_O(GPIO_OE_O),
  .NOMINAL_CAP_I(NOMINAL_CAP_I), .NOMINAL_CAP_LOAD_O(NOMINAL_CAP_LOAD_O),
  .FULL_CAP_LOAD_O(FULL_CAP_LOAD_O), .CAP_DATA_O(CAP_DATA_O),
  .PARTIAL_RESET_O(PARTIAL_RESET_O), .FULL_RESET_O(FULL_RESET_O), .SHIP_O(SHIP_O),
  .AT_RATE_O(AT_RATE_O));

/* verification/gmr_host_model.sv */
// Host model: byte port of the serial engine and the pulled-up GPIO line.
`timescale 1ns/1ns
module gmr_host_model
  import gmr_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       oe_i,
  input  wire logic       ext_low_i,
  input  wire logic [7:0] rdata_i,
  output logic      [6:0] addr_o,
  output logic      [7:0] wdata_o,
  output logic            wr_o,
  output logic            rd_o,
  output logic            pin_o
);
  // The line has a pull-up, so it is low only while a party pulls it.
  assign pin_o = !(oe_i || ext_low_i);

  initial begin
    addr_o = 7'h00;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end

  // Data is inverted on release so a stale byte can never pass for a fresh one.
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    wdata_o <= ~d;
  endtask

  // Read data is taken one cycle after the edge that accepts the strobe.
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    @(posedge clk_i);
    #1 d = rdata_i;
  endtask

  // A command is always two writes: the mode bits first, then the control byte.
  task automatic command(input logic [7:0] m, input logic [7:0] c);
    wr(ADDR_MODE, m);
    wr(ADDR_CTRL, c);
  endtask
endmodule // gmr_host_model

/* verification/gmr_regs_tb.sv */
// Self-checking testbench of the gauge register slice.
`timescale 1ns/1ns
module gmr_regs_tb;
  import gmr_pkg::*;
  localparam longint REFRESH = 64;

  logic        clk, rst, ext_low, full_chg, pin, oe, gpo, wr, rd;
  logic [6:0]  addr;
  logic [7:0]  pack_cfg, wdata, rdata, rd_val;
  logic [15:0] temp, mv, nom, at_rate_capacity, cap_data, at_rate;
  logic [4:0]  pv;
  int          n_errors, compares;
  logic [7:0]  modes [5] = '{8'hfb, 8'hdb, 8'hcb, 8'hc3, 8'hc1};

  gmr_host_model i_gmr_host_model (.clk_i(clk), .oe_i(oe), .ext_low_i(ext_low),
    .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd), .pin_o(pin));

  gmr_regs #(.REFRESH_CYCLES(REFRESH)) i_gmr_regs (.CLK_I(clk), .RST_I(rst), .CE_I(1'b1),
    .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata),
    .GPIO_I(pin), .GPIO_O(gpo), .GPIO_OE_O(oe), .PACK_CONFIG_I(pack_cfg),
    .FULL_CHARGE_I(full_chg), .NOMINAL_CAP_I(nom), .AT_RATE_CAP_I(at_rate_capacity), .DIE_TEMP_I(temp),
    .CELL_MV_I(mv), .NOMINAL_CAP_LOAD_O(pv[4]), .FULL_CAP_LOAD_O(pv[3]),
    .CAP_DATA_O(cap_data), .PARTIAL_RESET_O(pv[2]), .FULL_RESET_O(pv[1]), .SHIP_O(pv[0]),
    .AT_RATE_O(at_rate));

  // Clock at 50 MHz.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
    i_gmr_host_model.rd(a, rd_val);
    chk({8'h00, rd_val}, {8'h00, exp});
  endtask

  // Gathers every pulse over the window in which the command must run.
  task automatic cmd_chk(input logic [7:0] m, input logic [7:0] c, input logic [4:0] exp);
    logic [4:0] seen;
    seen = 5'h00;
    i_gmr_host_model.command(m, c);
    repeat (4) begin
      @(posedge clk);
      #1 seen = seen | pv;
    end
    chk({11'h000, seen}, {11'h000, exp});
  endtask

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Watchdog sized well above the roughly five hundred cycles the tests need.
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    end_of_test();
  end

  initial begin
    {rst, ext_low, full_chg, pack_cfg} = {3'b100, 8'h00};
    {temp, mv, nom, at_rate_capacity} = {16'h0492, 16'h1770, 16'h0abc, 16'h0064};
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    rd_chk(ADDR_MODE, 8'h44);
    rd_chk(ADDR_CTRL, 8'h00);
    $display("Test reset state done");
    i_gmr_host_model.wr(ADDR_MODE, 8'h00);
    rd_chk(ADDR_MODE, 8'h00);
    chk({15'h0000, oe}, 16'h0001);
    i_gmr_host_model.wr(ADDR_MODE, 8'h44);
    rd_chk(ADDR_MODE, 8'h44);
    chk({15'h0000, oe}, 16'h0000);
    @(posedge clk);
    full_chg <= 1'b1;
    @(posedge clk);
    full_chg <= 1'b0;
    rd_chk(ADDR_MODE, 8'h40);
    i_gmr_host_model.wr(ADDR_MODE, 8'h80);
    ext_low <= 1'b1;
    repeat (3) @(posedge clk);
    rd_chk(ADDR_MODE, 8'h80);
    chk({15'h0000, oe}, 16'h0000);
    ext_low <= 1'b0;
    repeat (3) @(posedge clk);
    rd_chk(ADDR_MODE, 8'hc0);
    $display("Test gpio done");
    // Direction reload after engine resets now reads input, so the pin level stays visible.
    pack_cfg <= 8'h80;
    i_gmr_host_model.wr(ADDR_AT_RATE_LO, 8'h34);
    i_gmr_host_model.wr(ADDR_AT_RATE_HI, 8'h12);
    rd_chk(ADDR_AT_RATE_LO, 8'h34);
    chk(at_rate, 16'h1234);
    cmd_chk(8'hc1, 8'h55, 5'h00);
    rd_chk(ADDR_MODE, 8'hc1);
    for (int k = 0; k < 5; k++) begin
      cmd_chk(modes[k], CTRL_KEY, 5'h10 >> k);
      i_gmr_host_model.rd(ADDR_MODE, rd_val);
      chk({8'h00, rd_val & 8'hfb}, 16'h00c0);
      rd_chk(ADDR_CTRL, 8'h00);
    end
    chk(at_rate, 16'h0000);
    $display("Test commands done");
    repeat (3 * REFRESH) @(posedge clk);
    rd_chk(ADDR_TEMP_LO, 8'h92);
    rd_chk(ADDR_TEMP_HI, 8'h04);
    rd_chk(ADDR_VOLT_LO, 8'h88);
    rd_chk(ADDR_VOLT_HI, 8'h13);
    rd_chk(ADDR_TTE_LO, 8'hff);
    i_gmr_host_model.wr(ADDR_TEMP_LO, 8'h00);
    i_gmr_host_model.wr(ADDR_TTE_LO, 8'h00);
    rd_chk(ADDR_TEMP_LO, 8'h92);
    rd_chk(ADDR_TTE_HI, 8'hff);
    rd_chk(7'h20, 8'h00);
    temp <= 16'h0493;
    mv <= 16'h0fa0;
    i_gmr_host_model.wr(ADDR_AT_RATE_LO, 8'h3c);
    i_gmr_host_model.wr(ADDR_AT_RATE_HI, 8'h00);
    repeat (2 * REFRESH) @(posedge clk);
    rd_chk(ADDR_TTE_LO, 8'h64);
    rd_chk(ADDR_TTE_HI, 8'h00);
    rd_chk(ADDR_TEMP_LO, 8'h93);
    rd_chk(ADDR_VOLT_HI, 8'h0f);
    $display("Test reports done");
    end_of_test();
  end
endmodule // gmr_regs_tb
